// ===== shared/csb_pkg.sv
// What this block does
// - Opcode 74 jumps when zero flag set
// - Opcode 7F jumps: zero clear, sign equals overflow
// - Opcode 7D jumps when sign equals overflow
// - Condition false: continue with next instruction
// - Target is one signed displacement byte
// - Extend byte: OR FF00 or mask 00FF
// - Taken: add displacement to pointer, wrap 16
// - Base is address after the jump
// - All three opcodes cost 13 or 4
// - Processor status flags never change
package csb_pkg;
  // ****************************************
  // Opcodes and flag positions
  // ****************************************
  localparam logic [7:0] OPC_JUMP_IF_EQUAL = 8'h74;
  localparam logic [7:0] OPC_JUMP_IF_SIGNED_GREATER_EQUAL = 8'h7D;
  localparam logic [7:0] OPC_JUMP_IF_SIGNED_GREATER = 8'h7F;
  localparam int FLAG_OVERFLOW_POS = 11;
  localparam int FLAG_SIGN_POS = 7;
  localparam int FLAG_ZERO_POS = 6;
  localparam int INSTR_LEN = 2;
  localparam logic [15:0] EXT_NEG_OR = 16'hFF00;
  localparam logic [15:0] EXT_POS_AND = 16'h00FF;
  // ****************************************
  // Timing counts in core clocks
  // ****************************************
  localparam int CLK_TAKEN = 13;
  localparam int CLK_NOT_TAKEN = 4;
  // ****************************************
  // Register map (word addresses are byte offsets)
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_OPCODE = 4'h4;
  localparam logic [3:0] ADDR_FLAGS = 4'h8;
  localparam logic [3:0] ADDR_IP = 4'hC;
  localparam int CTRL_START_POS = 0;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_TAKEN_POS = 1;
  localparam int STAT_BADOP_POS = 2;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] disp;
  } csb_instr_t;

  typedef enum logic [1:0] {
    CSB_IDLE = 2'b00,
    CSB_EXEC = 2'b01,
    CSB_DONE = 2'b11
  } csb_state_t;
endpackage : csb_pkg

// ===== hdl/csb_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none
module csb_branch_unit (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] instructionPointer,
  output logic branchDone
);
  import csb_pkg::*;

  // ****************************************
  // Condition and displacement helpers
  // ****************************************
  function automatic logic branch_cond(input logic [7:0] opc, input logic [15:0] fl);
    logic zf;
    logic sf;
    logic ovf;
    zf = fl[FLAG_ZERO_POS];
    sf = fl[FLAG_SIGN_POS];
    ovf = fl[FLAG_OVERFLOW_POS];
    unique case (opc)
      OPC_JUMP_IF_EQUAL: branch_cond = zf;
      OPC_JUMP_IF_SIGNED_GREATER: branch_cond = !zf && (sf == ovf);
      OPC_JUMP_IF_SIGNED_GREATER_EQUAL: branch_cond = (sf == ovf);
      default: branch_cond = 1'b0;
    endcase
  endfunction : branch_cond

  function automatic logic opc_known(input logic [7:0] opc);
    opc_known = (opc == OPC_JUMP_IF_EQUAL) || (opc == OPC_JUMP_IF_SIGNED_GREATER) ||
      (opc == OPC_JUMP_IF_SIGNED_GREATER_EQUAL);
  endfunction : opc_known

  function automatic logic [15:0] sign_ext(input logic [7:0] d);
    if (d[7])
      sign_ext = EXT_NEG_OR | {8'h00, d};
    else
      sign_ext = EXT_POS_AND & {8'h00, d};
  endfunction : sign_ext

  // ****************************************
  // State
  // ****************************************
  csb_state_t state_reg, state_next;
  csb_instr_t instr_reg, instr_next;
  logic [15:0] flags_reg, flags_next;
  logic [15:0] ip_reg, ip_next;
  logic [3:0] cnt_reg, cnt_next;
  logic taken_reg, taken_next;
  logic badop_reg, badop_next;
  logic done_reg, done_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wait_reg, wait_next;

  logic accessNow;
  logic writeNow;
  logic [15:0] nextIp;
  assign accessNow = (avs_read || avs_write) && wait_reg;
  // Writes land on the edge where the master sees waitrequest low, never earlier
  assign writeNow = avs_write && !wait_reg;
  assign nextIp = ip_reg + 16'(INSTR_LEN);

  always_comb
  begin
    state_next = state_reg;
    instr_next = instr_reg;
    flags_next = flags_reg;
    ip_next = ip_reg;
    cnt_next = cnt_reg;
    taken_next = taken_reg;
    badop_next = badop_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    // One wait cycle per access keeps read data registered
    wait_next = !accessNow;
    if (!(avs_read || avs_write))
      wait_next = 1'b1;
    if (writeNow && state_reg == CSB_IDLE)
    begin
      unique case (avs_address)
        ADDR_OPCODE: instr_next = csb_instr_t'(avs_writedata[15:0]);
        ADDR_FLAGS: flags_next = avs_writedata[15:0];
        ADDR_IP: ip_next = avs_writedata[15:0];
        ADDR_CTRL:
        begin
          if (avs_writedata[CTRL_START_POS])
          begin
            state_next = CSB_EXEC;
            taken_next = branch_cond(instr_reg.opcode, flags_reg);
            badop_next = !opc_known(instr_reg.opcode);
            cnt_next = branch_cond(instr_reg.opcode, flags_reg) ?
              4'(CLK_TAKEN - 1) : 4'(CLK_NOT_TAKEN - 1);
          end
        end
        default: ;
      endcase
    end
    if (accessNow && avs_read)
    begin
      unique case (avs_address)
        ADDR_CTRL: rdata_next = {29'h0, badop_reg, taken_reg, state_reg != CSB_IDLE};
        ADDR_OPCODE: rdata_next = {16'h0, instr_reg};
        ADDR_FLAGS: rdata_next = {16'h0, flags_reg};
        ADDR_IP: rdata_next = {16'h0, ip_reg};
        default: rdata_next = UNMAPPED_READ;
      endcase
    end
    unique case (state_reg)
      CSB_IDLE: ;
      CSB_EXEC:
      begin
        if (cnt_reg == 4'h1)
          state_next = CSB_DONE;
        else
          cnt_next = cnt_reg - 4'h1;
      end
      CSB_DONE:
      begin
        ip_next = taken_reg ? nextIp + sign_ext(instr_reg.disp) : nextIp;
        cnt_next = 4'h0;
        done_next = 1'b1;
        state_next = CSB_IDLE;
      end
      default: state_next = CSB_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= CSB_IDLE;
      instr_reg <= '0;
      flags_reg <= 16'h0000;
      ip_reg <= 16'h0000;
      cnt_reg <= 4'h0;
      taken_reg <= 1'b0;
      badop_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      wait_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      instr_reg <= instr_next;
      flags_reg <= flags_next;
      ip_reg <= ip_next;
      cnt_reg <= cnt_next;
      taken_reg <= taken_next;
      badop_reg <= badop_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign instructionPointer = ip_reg;
  assign branchDone = done_reg;

  // ****************************************
  // Checks
  // ****************************************
  // Cycles spent away from idle; cleared in idle so a finished branch
  // never leaves a stale count behind for the next instruction
  logic [3:0] runLen;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      runLen <= 4'h0;
    else if (state_reg == CSB_IDLE)
      runLen <= 4'h0;
    else
      runLen <= runLen + 4'h1;
  end

  // ****************************************
  // Bus protocol checks
  // ****************************************
  // Waitrequest drops for exactly one cycle per access
  property p_wait_single;
    @(posedge clock) disable iff (!reset_n)
      !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_single: assert property (p_wait_single) else $error("waitrequest low twice");

  // An answer always follows a request seen one edge earlier
  property p_wait_cause;
    @(posedge clock) disable iff (!reset_n)
      $fell(avs_waitrequest) |-> ($past(avs_read) || $past(avs_write));
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");

  // Read data moves only when a read is captured, so it stands until the next read
  property p_rdata_hold;
    @(posedge clock) disable iff (!reset_n)
      $changed(avs_readdata) |-> $past(avs_read);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // ****************************************
  // Execution checks
  // ****************************************
  // Both costs run from the start edge to the edge that raises the done pulse
  property p_taken_cost;
    @(posedge clock) disable iff (!reset_n)
      (done_reg && taken_reg) |-> (runLen == 4'(CLK_TAKEN));
  endproperty
  a_taken_cost: assert property (p_taken_cost) else $error("taken cost wrong");

  property p_nt_cost;
    @(posedge clock) disable iff (!reset_n)
      (done_reg && !taken_reg) |-> (runLen == 4'(CLK_NOT_TAKEN));
  endproperty
  a_nt_cost: assert property (p_nt_cost) else $error("fall-through cost wrong");

  // A failed test only steps past the two instruction bytes
  property p_fall;
    @(posedge clock) disable iff (!reset_n)
      (state_reg == CSB_DONE && !taken_reg) |=> (ip_reg == $past(ip_reg) + 16'(INSTR_LEN));
  endproperty
  a_fall: assert property (p_fall) else $error("fall-through pointer wrong");

  // The extension is written out here apart from the helper function
  property p_jump;
    @(posedge clock) disable iff (!reset_n)
      (state_reg == CSB_DONE && taken_reg) |=>
      (ip_reg == $past(ip_reg) + 16'(INSTR_LEN) +
      {{8{$past(instr_reg.disp[7])}}, $past(instr_reg.disp)});
  endproperty
  a_jump: assert property (p_jump) else $error("taken pointer wrong");

  // The pointer moves only in the done state or on a register write
  property p_ip_hold;
    @(posedge clock) disable iff (!reset_n)
      (state_reg != CSB_DONE &&
      !(avs_write && !avs_waitrequest && avs_address == ADDR_IP)) |=> $stable(ip_reg);
  endproperty
  a_ip_hold: assert property (p_ip_hold) else $error("pointer moved early");

  // Displacement and opcode stay put while a branch is under way
  property p_instr_hold;
    @(posedge clock) disable iff (!reset_n)
      (state_reg != CSB_IDLE) |=> $stable(instr_reg);
  endproperty
  a_instr_hold: assert property (p_instr_hold) else $error("operand changed");

  // Flag writes are refused while busy and nothing else writes them
  property p_flags;
    @(posedge clock) disable iff (!reset_n)
      (state_reg != CSB_IDLE) |=> $stable(flags_reg);
  endproperty
  a_flags: assert property (p_flags) else $error("flags changed");

  // The done pulse comes only out of the done state
  property p_done_src;
    @(posedge clock) disable iff (!reset_n)
      $rose(done_reg) |-> ($past(state_reg) == CSB_DONE);
  endproperty
  a_done_src: assert property (p_done_src) else $error("stray done pulse");

  // ****************************************
  // Decision checks
  // ****************************************
  // Sampled on the first execute cycle, against the flags that started it
  property p_eq;
    @(posedge clock) disable iff (!reset_n)
      ($rose(state_reg == CSB_EXEC) && instr_reg.opcode == OPC_JUMP_IF_EQUAL) |->
      (taken_reg == flags_reg[FLAG_ZERO_POS]);
  endproperty
  a_eq: assert property (p_eq) else $error("equal test wrong");

  property p_gt;
    @(posedge clock) disable iff (!reset_n)
      ($rose(state_reg == CSB_EXEC) && instr_reg.opcode == OPC_JUMP_IF_SIGNED_GREATER) |->
      (taken_reg == (!flags_reg[FLAG_ZERO_POS] &&
      flags_reg[FLAG_SIGN_POS] == flags_reg[FLAG_OVERFLOW_POS]));
  endproperty
  a_gt: assert property (p_gt) else $error("greater test wrong");

  property p_ge;
    @(posedge clock) disable iff (!reset_n)
      ($rose(state_reg == CSB_EXEC) &&
      instr_reg.opcode == OPC_JUMP_IF_SIGNED_GREATER_EQUAL) |->
      (taken_reg == (flags_reg[FLAG_SIGN_POS] == flags_reg[FLAG_OVERFLOW_POS]));
  endproperty
  a_ge: assert property (p_ge) else $error("greater-equal test wrong");

  // Opcodes outside the three never branch and are flagged as unknown
  property p_bad_fall;
    @(posedge clock) disable iff (!reset_n)
      ($rose(state_reg == CSB_EXEC) && !opc_known(instr_reg.opcode)) |->
      (!taken_reg && badop_reg);
  endproperty
  a_bad_fall: assert property (p_bad_fall) else $error("unknown opcode branched");

  // ****************************************
  // Coverage
  // ****************************************
  c_taken: cover property (@(posedge clock) done_reg && taken_reg);
  c_fall: cover property (@(posedge clock) done_reg && !taken_reg);
  c_back: cover property (@(posedge clock) state_reg == CSB_DONE && taken_reg && instr_reg.disp[7]);
  c_badop: cover property (@(posedge clock) done_reg && badop_reg);
  c_busy_write: cover property (@(posedge clock)
    state_reg != CSB_IDLE && avs_write && !avs_waitrequest);
endmodule : csb_branch_unit
`default_nettype wire

// ===== bench/test_conditional_short_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_conditional_short_branch_unit;
  import csb_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] instructionPointer;
  logic branchDone;
  logic [15:0] lfsrState = 16'h0013;
  logic [31:0] rdData;
  logic [7:0] opTable [4] = '{8'h74, 8'h7D, 8'h7F, 8'h7E};
  int num_errors = 0;
  int n_tests = 0;

  csb_branch_unit dut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .instructionPointer(instructionPointer), .branchDone(branchDone));

  always #4 clock = ~clock;

  // ****************************************
  // Expectation helpers
  // ****************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Flag triple is {zero, sign, overflow}
  function automatic logic cond_met(input logic [7:0] op, input logic [2:0] zso);
    case (op)
      OPC_JUMP_IF_EQUAL: return zso[2];
      OPC_JUMP_IF_SIGNED_GREATER: return !zso[2] && (zso[1] == zso[0]);
      OPC_JUMP_IF_SIGNED_GREATER_EQUAL: return zso[1] == zso[0];
      default: return 1'b0;
    endcase
  endfunction : cond_met

  function automatic logic [15:0] sext(input logic [7:0] d);
    return d[7] ? (EXT_NEG_OR | {8'h00, d}) : (EXT_POS_AND & {8'h00, d});
  endfunction : sext

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    n_tests++;
    if (seen !== expected)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  // Waits an edge first so a release and a new request never share a time step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rdData = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic run(input logic [7:0] op, input logic [7:0] d, input logic [2:0] zso,
                     input logic [15:0] ip);
    logic tk;
    logic badOp;
    logic [15:0] fl;
    int cnt;
    tk = cond_met(op, zso);
    badOp = !(op inside {OPC_JUMP_IF_EQUAL, OPC_JUMP_IF_SIGNED_GREATER,
                         OPC_JUMP_IF_SIGNED_GREATER_EQUAL});
    // Unrelated flag bits are random so the decision must ignore them
    fl = lfsr_next(ip ^ {op, d});
    fl[FLAG_ZERO_POS] = zso[2];
    fl[FLAG_SIGN_POS] = zso[1];
    fl[FLAG_OVERFLOW_POS] = zso[0];
    cnt = 0;
    bus(1'b1, ADDR_OPCODE, {16'h0, op, d});
    bus(1'b1, ADDR_FLAGS, {16'h0, fl});
    bus(1'b1, ADDR_IP, {16'h0, ip});
    bus(1'b1, ADDR_CTRL, 32'h1);
    while (branchDone !== 1'b1 && cnt < 100)
    begin
      @(negedge clock);
      cnt++;
    end
    check(32'(cnt), 32'(tk ? CLK_TAKEN + 1 : CLK_NOT_TAKEN + 1));
    check({16'h0, instructionPointer}, {16'h0, ip + 16'(INSTR_LEN) + (tk ? sext(d) : 16'h0)});
    @(negedge clock);
    check({31'h0, branchDone}, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check({29'h0, rdData[2:0]}, {29'h0, badOp, tk, 1'b0});
    bus(1'b0, ADDR_FLAGS, 32'h0);
    check(rdData, {16'h0, fl});
  endtask : run

  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    check({16'h0, instructionPointer}, 32'h0);
    bus(1'b0, 4'h6, 32'h0);
    check(rdData, UNMAPPED_READ);
    // Corners: wrap below zero, wrap above FFFF, an out-of-scope opcode
    run(OPC_JUMP_IF_EQUAL, 8'h80, 3'b100, 16'h0000);
    run(OPC_JUMP_IF_SIGNED_GREATER_EQUAL, 8'h7F, 3'b011, 16'hFFF0);
    run(8'h7C, 8'h10, 3'b010, 16'h1000);
    // Busy window: status reports busy and a flag write is refused
    bus(1'b1, ADDR_OPCODE, {16'h0, OPC_JUMP_IF_EQUAL, 8'h05});
    bus(1'b1, ADDR_FLAGS, {16'h0, 16'(1 << FLAG_ZERO_POS)});
    bus(1'b1, ADDR_IP, 32'h0000_0100);
    bus(1'b1, ADDR_CTRL, 32'h1);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check(rdData, 32'h0000_0003);
    bus(1'b1, ADDR_FLAGS, 32'h0000_FFFF);
    while (branchDone !== 1'b1)
      @(negedge clock);
    check({16'h0, instructionPointer}, 32'h0000_0107);
    bus(1'b0, ADDR_FLAGS, 32'h0);
    check(rdData, {16'h0, 16'(1 << FLAG_ZERO_POS)});
    // Reset in mid-branch: the branch is dropped and the state clears
    bus(1'b1, ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    check({16'h0, instructionPointer}, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check(rdData, 32'h0);
    for (int i = 0; i < 32; i++)
    begin
      lfsrState = lfsr_next(lfsrState);
      run(opTable[i[4:3]], lfsrState[7:0], i[2:0], lfsr_next(lfsrState));
    end
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    report_and_stop();
  end
endmodule : test_conditional_short_branch_unit
`default_nettype wire
